// File: common/dpp_pkg.sv
// Package: constants and types of the dual PCM port framing block
`default_nettype none
package dpp_pkg;
   // Clock and frame timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int FRAME_PERIOD_NS = 125000;
   // Two silent frames on the frame pulse pin mean it is tied low
   localparam int TIED_LOW_NS = 2 * FRAME_PERIOD_NS;
   localparam int TIED_LOW_CYC = TIED_LOW_NS / CLK_PERIOD_NS;
   // Strobe lengths in data bits
   localparam logic [4:0] NARROW_BITS = 5'h08;
   localparam logic [4:0] WIDE_BITS = 5'h10;
   localparam int FIFO_DEPTH = 8;
   localparam int WORD_W = 16;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_LINE_TX = 8'h08;
   localparam logic [7:0] REG_MIC_TX = 8'h0C;
   localparam logic [7:0] REG_LINE_RX = 8'h10;
   localparam logic [7:0] REG_MIC_RX = 8'h14;
   // Control fields
   localparam int CTRL_LINE_WIDE = 0;
   localparam int CTRL_MIC_WIDE = 1;
   localparam int CTRL_LINE_EN = 2;
   localparam int CTRL_MIC_EN = 3;
   localparam int CTRL_FP_HIGH = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000000C;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Framing mode of the PCM ports
   typedef enum logic [1:0] {DPP_STROBED, DPP_BUS_LOW, DPP_BUS_HIGH} dpp_link_e;
endpackage
`default_nettype wire

// File: logic/dpp_port_framing.sv
// Dual PCM port framing: strobed serial lanes, mode decode, AXI4-Lite registers
//
// Behaviour
// [R1] Line port moves data only while strobe high
// [R2] Line strobe supplied externally, every 125 us
// [R3] Mic strobe high, 8/16 bits, gates mic data
// [R4] Mode selects held low in strobed mode
// [R5] Bus modes: line strobe plus select give sub-mode
// [R6] Bus modes: mic strobe plus select give sub-mode
// [R7] Each port pair keeps its own format
// [R8] Frame pulse tied low selects strobed mode
// [R9] Streams run from 128 to 4096 kbps
// [R10] Companding pin: high A-law, low mu-law
// [R11] Format pin: high G.711, low sign-magnitude
// [R12] Outputs driven only while strobe high; the code releases them at the first bit clock rise after the strobe falls
`default_nettype none

// Word buffer with valid/ready on both sides
module dpp_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = dpp_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrIdx;
   logic [AW-1:0] rdIdx;
   logic [AW:0] count;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] idx);
      bump = (idx == AW'(DEPTH - 1)) ? '0 : idx + 1'b1;
   endfunction

   // Honest flags from the occupancy count
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdIdx];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // Storage
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wrIdx] <= inData;
      end
   end

   // Pointers and count
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrIdx <= '0;
         rdIdx <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrIdx <= bump(wrIdx);
         end
         if (pop) begin
            rdIdx <= bump(rdIdx);
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// One strobed serial port pair: input capture and output shift
module dpp_lane (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Synchronised link
   input wire logic bitRise,
   input wire logic bitFall,
   input wire logic strobe,
   input wire logic serIn,
   // Control
   input wire logic enable,
   input wire logic wide16,
   input wire logic [15:0] txWord,
   // Serial output
   output logic serOut,
   output logic serOeN,
   // Received words
   output logic popValid,
   input wire logic popReady,
   output logic [16:0] popData
);
   logic inFrame;
   logic capture;
   logic [15:0] txShift;
   logic [15:0] rxShift;
   logic [4:0] rxCount;
   logic pushValid;
   logic pushReady;
   logic [16:0] pushData;
   logic frameStart;
   logic frameEnd;

   assign frameStart = bitRise && strobe && !inFrame;
   assign frameEnd = bitRise && !strobe && inFrame;

   // Frame tracking; a full buffer stalls capture for the whole frame
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         inFrame <= 1'b0;
         capture <= 1'b0;
      end else if (!enable) begin
         inFrame <= 1'b0;
         capture <= 1'b0;
      end else if (frameStart) begin
         inFrame <= 1'b1; // see [R1] see [R3]
         capture <= pushReady;
      end else if (frameEnd) begin
         inFrame <= 1'b0;
      end
   end

   // Output shifter, MSB first, changes on bit clock rise
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         serOut <= 1'b0;
         serOeN <= 1'b1;
         txShift <= '0;
      end else if (!enable || (bitRise && !strobe)) begin
         serOeN <= 1'b1; // see [R12]
      end else if (frameStart) begin
         serOeN <= 1'b0; // see [R12]
         serOut <= wide16 ? txWord[15] : txWord[7]; // see [R7]
         txShift <= wide16 ? {txWord[14:0], 1'b0} : {txWord[6:0], 9'h000};
      end else if (bitRise && strobe) begin
         serOut <= txShift[15]; // see [R1]
         txShift <= {txShift[14:0], 1'b0};
      end
   end

   // Input shifter, samples on bit clock fall inside the strobe
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxShift <= '0;
         rxCount <= '0;
      end else if (frameStart) begin
         rxCount <= '0;
      end else if (bitFall && inFrame && capture && strobe) begin
         rxShift <= {rxShift[14:0], serIn}; // see [R3]
         if (rxCount != 5'h1F) begin
            rxCount <= rxCount + 1'b1;
         end
      end
   end

   // Only 8 or 16 bit strobes yield a word; others are dropped
   assign pushValid = frameEnd && capture &&
                      (rxCount == dpp_pkg::NARROW_BITS || rxCount == dpp_pkg::WIDE_BITS);
   assign pushData = (rxCount == dpp_pkg::WIDE_BITS) ? {1'b1, rxShift} :
                     {9'h000, rxShift[7:0]};

   dpp_fifo #(.WIDTH(17), .DEPTH(dpp_pkg::FIFO_DEPTH)) rxBuf (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(pushData),
      .outValid(popValid),
      .outReady(popReady),
      .outData(popData)
   );
endmodule

// Top: pin synchronisers, mode decode, lanes and register slave
module dpp_port_framing #(
   parameter int TIED_LOW_CYCLES = dpp_pkg::TIED_LOW_CYC
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // PCM pins
   input wire logic pcmBitClk,
   input wire logic framePulseIn,
   input wire logic linePortStrobe,
   input wire logic micPortStrobe,
   input wire logic linePortModeSel,
   input wire logic micPortModeSel,
   input wire logic lineRxIn,
   input wire logic micTxIn,
   output logic lineTxOut,
   output logic lineTxOeN,
   output logic micRxOut,
   output logic micRxOeN,
   // Coding select pins
   input wire logic lawSelA,
   input wire logic codeSelItu
);
   logic [9:0] pinMeta;
   logic [9:0] pinSync;
   logic bitPrev;
   logic bitRise;
   logic bitFall;
   logic busMode;
   logic [$clog2(TIED_LOW_CYCLES+1)-1:0] quietCnt;
   dpp_pkg::dpp_link_e linkMode;
   logic strobed;
   logic [31:0] ctrl;
   logic [15:0] lineTxWord;
   logic [15:0] micTxWord;
   logic linePopValid;
   logic micPopValid;
   logic [16:0] linePopData;
   logic [16:0] micPopData;
   logic [1:0] lineSub;
   logic [1:0] micSub;
   logic [31:0] status;
   logic wrFire;
   logic rdFire;
   logic [31:0] rdMux;
   logic rdOk;
   logic wrOk;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         old[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
      merge = old;
   endfunction

   // Two flops on every pin; bit clock edges seen at up to 4096 kbps
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinMeta <= '0;
         pinSync <= '0;
         bitPrev <= 1'b0;
      end else begin
         pinMeta <= {codeSelItu, lawSelA, micTxIn, lineRxIn, micPortModeSel,
                     linePortModeSel, micPortStrobe, linePortStrobe, framePulseIn, pcmBitClk};
         pinSync <= pinMeta; // see [R9]
         bitPrev <= pinSync[0];
      end
   end
   assign bitRise = pinSync[0] && !bitPrev;
   assign bitFall = !pinSync[0] && bitPrev;

   // Frame pulse quiet for two frames means tied low: strobed mode
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busMode <= 1'b0;
         quietCnt <= '0;
      end else if (pinSync[1]) begin
         busMode <= 1'b1; // see [R8]
         quietCnt <= '0;
      end else if (quietCnt == $bits(quietCnt)'(TIED_LOW_CYCLES - 1)) begin
         busMode <= 1'b0; // see [R8]
      end else begin
         quietCnt <= quietCnt + 1'b1;
      end
   end

   // Pulse polarity of the bus modes is told by software
   always_comb begin
      if (!busMode) begin
         linkMode = dpp_pkg::DPP_STROBED;
      end else if (ctrl[dpp_pkg::CTRL_FP_HIGH]) begin
         linkMode = dpp_pkg::DPP_BUS_HIGH; // see [R8]
      end else begin
         linkMode = dpp_pkg::DPP_BUS_LOW;
      end
   end
   assign strobed = (linkMode == dpp_pkg::DPP_STROBED);

   // Strobe pins turn into static sub-mode bits in the bus modes
   assign lineSub = strobed ? 2'h0 : {pinSync[4], pinSync[2]}; // see [R5]
   assign micSub = strobed ? 2'h0 : {pinSync[5], pinSync[3]}; // see [R6]

   // Line pair: receive input in, send output out
   dpp_lane lineLane (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .bitRise(bitRise),
      .bitFall(bitFall),
      .strobe(pinSync[2]), // see [R2]
      .serIn(pinSync[6]),
      .enable(strobed && ctrl[dpp_pkg::CTRL_LINE_EN]), // see [R1]
      .wide16(ctrl[dpp_pkg::CTRL_LINE_WIDE]), // see [R7]
      .txWord(lineTxWord),
      .serOut(lineTxOut),
      .serOeN(lineTxOeN),
      .popValid(linePopValid),
      .popReady(rdFire && s_axi_araddr == dpp_pkg::REG_LINE_RX),
      .popData(linePopData)
   );

   // Mic pair: send input in, receive output out
   dpp_lane micLane (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .bitRise(bitRise),
      .bitFall(bitFall),
      .strobe(pinSync[3]),
      .serIn(pinSync[7]),
      .enable(strobed && ctrl[dpp_pkg::CTRL_MIC_EN]), // see [R3]
      .wide16(ctrl[dpp_pkg::CTRL_MIC_WIDE]), // see [R7]
      .txWord(micTxWord),
      .serOut(micRxOut),
      .serOeN(micRxOeN),
      .popValid(micPopValid),
      .popReady(rdFire && s_axi_araddr == dpp_pkg::REG_MIC_RX),
      .popData(micPopData)
   );

   // Status word; select pins high in strobed mode flag misuse
   assign status = {20'h00000,
                    strobed && pinSync[5], strobed && pinSync[4], // see [R4]
                    micPopValid, linePopValid, micSub, lineSub,
                    pinSync[9], pinSync[8], // see [R10] see [R11]
                    linkMode == dpp_pkg::DPP_BUS_HIGH, busMode};

   // Write channel: address and data taken together, one at a time
   assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wrFire;
   assign s_axi_wready = wrFire;
   assign wrOk = (s_axi_awaddr == dpp_pkg::REG_CTRL) ||
                 (s_axi_awaddr == dpp_pkg::REG_LINE_TX) ||
                 (s_axi_awaddr == dpp_pkg::REG_MIC_TX);

   // Writable registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= dpp_pkg::CTRL_RESET;
         lineTxWord <= '0;
         micTxWord <= '0;
      end else if (wrFire) begin
         case (s_axi_awaddr)
            dpp_pkg::REG_CTRL: ctrl <= merge(ctrl, s_axi_wdata, s_axi_wstrb) & 32'h0000001F;
            dpp_pkg::REG_LINE_TX: lineTxWord <= 16'(merge({16'h0000, lineTxWord}, s_axi_wdata,
                                                          s_axi_wstrb));
            dpp_pkg::REG_MIC_TX: micTxWord <= 16'(merge({16'h0000, micTxWord}, s_axi_wdata,
                                                        s_axi_wstrb));
            default: ctrl <= ctrl;
         endcase
      end
   end

   // Write response, one cycle after the take
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= dpp_pkg::RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrOk ? dpp_pkg::RESP_OKAY : dpp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read decode; reading a receive register pops its buffer
   assign rdFire = s_axi_arvalid && !s_axi_rvalid;
   assign s_axi_arready = !s_axi_rvalid;
   always_comb begin
      rdOk = 1'b1;
      case (s_axi_araddr)
         dpp_pkg::REG_CTRL: rdMux = ctrl;
         dpp_pkg::REG_STATUS: rdMux = status;
         dpp_pkg::REG_LINE_TX: rdMux = {16'h0000, lineTxWord};
         dpp_pkg::REG_MIC_TX: rdMux = {16'h0000, micTxWord};
         dpp_pkg::REG_LINE_RX: rdMux = {linePopValid, 14'h0000, linePopData};
         dpp_pkg::REG_MIC_RX: rdMux = {micPopValid, 14'h0000, micPopData};
         default: begin
            rdMux = 32'h00000000;
            rdOk = 1'b0;
         end
      endcase
   end

   // Read answer, one cycle after the take
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= dpp_pkg::RESP_OKAY;
      end else if (rdFire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= rdOk ? dpp_pkg::RESP_OKAY : dpp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// File: tb/dpp_port_framing_properties.sv
// Checker: bus handshake and PCM drive-window properties of the top
`default_nettype none
module dpp_port_framing_properties (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // PCM pins
   input wire logic framePulseIn,
   input wire logic linePortStrobe,
   input wire logic micPortStrobe,
   input wire logic lineTxOeN,
   input wire logic micRxOeN
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   logic [5:0] lineIdle;
   logic [5:0] micIdle;
   // Cycles since a strobe was high; the enable may lag by one bit period
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) lineIdle <= 6'h3F;
      else if (linePortStrobe) lineIdle <= 6'h00;
      else if (lineIdle != 6'h3F) lineIdle <= lineIdle + 6'h01;
   end
   // Same count for the mic strobe
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) micIdle <= 6'h3F;
      else if (micPortStrobe) micIdle <= 6'h00;
      else if (micIdle != 6'h3F) micIdle <= micIdle + 6'h01;
   end
   sequence s_wr_take;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   endsequence
   a_wr_ready: assert property (s_axi_awready |-> s_wr_take)
      else $error("write taken without both channels");
   a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rd_ready: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read ready wrong");
   a_rd_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
      else $error("read response late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_line_gate: assert property (!lineTxOeN |-> lineIdle < 6'h18)
      else $error("line output driven outside strobe");
   a_mic_gate: assert property (!micRxOeN |-> micIdle < 6'h18)
      else $error("mic output driven outside strobe");
   a_bus_quiet: assert property (framePulseIn [*6] |-> lineTxOeN && micRxOeN)
      else $error("output driven in bus mode");
endmodule
`default_nettype wire

// File: tb/dpp_pcm_partner.sv
// Codec model: bit clock, strobes and serial data for both port pairs
`default_nettype none
module dpp_pcm_partner (
   // Link outputs
   output logic pcmBitClk,
   output logic linePortStrobe,
   output logic micPortStrobe,
   output logic lineRxIn,
   output logic micTxIn,
   // Device outputs
   input wire logic lineTxOut,
   input wire logic lineTxOeN,
   input wire logic micRxOut,
   input wire logic micRxOeN
);
   timeunit 1ns;
   timeprecision 1ps;
   // Clock stands still outside frames
   initial begin
      pcmBitClk = 1'b0;
      linePortStrobe = 1'b0;
      micPortStrobe = 1'b0;
      lineRxIn = 1'b0;
      micTxIn = 1'b0;
   end
   // Static levels for bus mode
   task automatic set_static(input logic l, input logic m);
      linePortStrobe <= l;
      micPortStrobe <= m;
   endtask
   // One frame; strobe rises just after a falling edge, data MSB first
   task automatic frame(input logic mic, input int n, input logic [15:0] din,
                        output logic [15:0] dout, output logic oe);
      dout = 16'h0000;
      oe = 1'b1;
      // Off the core clock grid when started on a clock edge; a frame called straight after another can move a pin on a sampling edge
      #0.25;
      if (mic) micPortStrobe = 1'b1;
      else linePortStrobe = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         #62.5 pcmBitClk = 1'b1;
         if (mic) micTxIn = din[i[3:0]];
         else lineRxIn = din[i[3:0]];
         #62.5 pcmBitClk = 1'b0;
         dout = {dout[14:0], mic ? micRxOut : lineTxOut};
         oe = oe & !(mic ? micRxOeN : lineTxOeN);
      end
      // Strobe drops mid low phase, so the last fall is still seen inside it
      #31;
      if (mic) micPortStrobe = 1'b0;
      else linePortStrobe = 1'b0;
      // Released data line shows the inverse, so a stale bit cannot pass
      if (mic) micTxIn = !micTxIn;
      else lineRxIn = !lineRxIn;
      #31.5 pcmBitClk = 1'b1;
      #62.5 pcmBitClk = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Testbench top: register tasks, PCM frames and verdict
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic pcmBitClk, framePulseIn, linePortStrobe, micPortStrobe, linePortModeSel;
   logic micPortModeSel, lineRxIn, micTxIn, lineTxOut, lineTxOeN, micRxOut, micRxOeN;
   logic lawSelA, codeSelItu;
   int mismatches = 0;
   int numChecks = 0;
   // Short tied-low count keeps mode changes quick
   dpp_port_framing #(.TIED_LOW_CYCLES(100)) u_dpp_port_framing (.core_clk, .sys_rst,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .pcmBitClk, .framePulseIn, .linePortStrobe,
      .micPortStrobe, .linePortModeSel, .micPortModeSel, .lineRxIn, .micTxIn, .lineTxOut,
      .lineTxOeN, .micRxOut, .micRxOeN, .lawSelA, .codeSelItu);
   dpp_pcm_partner u_dpp_pcm_partner (.pcmBitClk, .linePortStrobe, .micPortStrobe,
      .lineRxIn, .micTxIn, .lineTxOut, .lineTxOeN, .micRxOut, .micRxOeN);
   always #4 core_clk = ~core_clk;
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", numChecks, mismatches);
      if (mismatches == 0 && numChecks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Write; bready is raised a cycle after the write is taken, so the response waits one cycle before it is accepted
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      s_axi_bready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_bvalid);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      @(posedge core_clk);
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Whole run is some 30 us, mostly frames; far beyond that means a hang
   initial begin
      #300us;
      mismatches++;
      complete_run;
   end
   initial begin
      logic [31:0] d;
      logic [15:0] w;
      logic oe;
      logic [1:0] r;
      {core_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b01000;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {framePulseIn, linePortModeSel, micPortModeSel, lawSelA, codeSelItu} = '0;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (120) @(posedge core_clk);
      rd(dpp_pkg::REG_CTRL, d, r);
      chk("ctrl reset", d, dpp_pkg::CTRL_RESET);
      // Coding pins reported in two separate status bits, strobed mode seen
      for (int i = 0; i < 4; i++) begin
         lawSelA <= i[0];
         codeSelItu <= i[1];
         repeat (4) @(posedge core_clk);
         rd(dpp_pkg::REG_STATUS, d, r);
         chk("status pins", d & 32'h0000000F, {28'h0, i[1:0], 2'b00});
      end
      wr(8'h20, 32'h00000001, dpp_pkg::RESP_SLVERR);
      wr(dpp_pkg::REG_STATUS, 32'h00000001, dpp_pkg::RESP_SLVERR);
      rd(8'h20, d, r);
      chk("unmapped rresp", {30'h0, r}, {30'h0, dpp_pkg::RESP_SLVERR});
      wr(dpp_pkg::REG_LINE_TX, 32'h0000A5C3, dpp_pkg::RESP_OKAY);
      wr(dpp_pkg::REG_MIC_TX, 32'h00001234, dpp_pkg::RESP_OKAY);
      wr(dpp_pkg::REG_CTRL, 32'h0000000D, dpp_pkg::RESP_OKAY);
      // Line wide, mic narrow: each pair keeps its own width
      u_dpp_pcm_partner.frame(1'b0, 16, 16'hBEEF, w, oe);
      chk("line tx", {15'h0, oe, w}, 32'h0001A5C3);
      u_dpp_pcm_partner.frame(1'b1, 8, 16'h005A, w, oe);
      chk("mic tx", {15'h0, oe, w}, 32'h00010034);
      rd(dpp_pkg::REG_LINE_RX, d, r);
      chk("line rx", d, 32'h8001BEEF);
      rd(dpp_pkg::REG_MIC_RX, d, r);
      chk("mic rx", d, 32'h8000005A);
      u_dpp_pcm_partner.frame(1'b0, 12, 16'h0ABC, w, oe);
      rd(dpp_pkg::REG_LINE_RX, d, r);
      chk("odd span dropped", d & 32'h80000000, 32'h0);
      // One frame more than the buffer holds, then drain to empty
      for (int i = 0; i <= dpp_pkg::FIFO_DEPTH; i++)
         u_dpp_pcm_partner.frame(1'b0, 16, {8'h01, i[7:0]}, w, oe);
      for (int i = 0; i <= dpp_pkg::FIFO_DEPTH; i++) begin
         rd(dpp_pkg::REG_LINE_RX, d, r);
         if (i < dpp_pkg::FIFO_DEPTH) chk("drain", d, {16'h8001, 8'h01, i[7:0]});
         else chk("drain empty", d & 32'h80000000, 32'h0);
      end
      linePortModeSel <= 1'b1;
      micPortModeSel <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd(dpp_pkg::REG_STATUS, d, r);
      chk("mode select flags", d & 32'h00000C00, 32'h00000C00);
      // Bus mode: strobes become static sub-mode bits, outputs stay off
      framePulseIn <= 1'b1;
      // Pulse polarity bit still clear: the active-low bus mode first
      repeat (4) @(posedge core_clk);
      rd(dpp_pkg::REG_STATUS, d, r);
      chk("bus low", d & 32'h00000003, 32'h00000001);
      wr(dpp_pkg::REG_CTRL, 32'h0000001D, dpp_pkg::RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         linePortModeSel <= i[1];
         micPortModeSel <= !i[1];
         u_dpp_pcm_partner.set_static(i[0], !i[0]);
         repeat (6) @(posedge core_clk);
         rd(dpp_pkg::REG_STATUS, d, r);
         chk("sub-mode", d & 32'h000000F3, {24'h0, !i[1], !i[0], i[1:0], 4'h3});
      end
      u_dpp_pcm_partner.set_static(1'b0, 1'b0);
      u_dpp_pcm_partner.frame(1'b0, 8, 16'h00FF, w, oe);
      chk("bus mode undriven", {31'h0, oe}, 32'h0);
      framePulseIn <= 1'b0;
      linePortModeSel <= 1'b0;
      micPortModeSel <= 1'b0;
      repeat (120) @(posedge core_clk);
      rd(dpp_pkg::REG_STATUS, d, r);
      chk("strobed again", d & 32'h00000001, 32'h0);
      complete_run;
   end
endmodule
bind dpp_port_framing dpp_port_framing_properties u_dpp_port_framing_properties (.core_clk,
   .sys_rst, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .framePulseIn, .linePortStrobe, .micPortStrobe, .lineTxOeN, .micRxOeN);
`default_nettype wire
